// ===== logic/fp_exc_pkg.sv
package fp_exc_pkg;

  // condition flag vector layout
  localparam int FLAG_W   = 13;
  localparam int TAG_W    = 8;
  localparam int ENABLE_W = 5;

  localparam int INV_SIGNALING_NAN    = 0;
  localparam int INV_INF_MINUS_INF    = 1;
  localparam int INV_INF_DIV_INF      = 2;
  localparam int INV_ZERO_DIV_ZERO    = 3;
  localparam int INV_INF_TIMES_ZERO   = 4;
  localparam int INV_COMPARE          = 5;
  localparam int INV_SOFTWARE_REQUEST = 6;
  localparam int INV_INTEGER_CONVERT  = 7;
  localparam int INV_SQUARE_ROOT      = 8;
  localparam int ZERO_DIVIDE_FLAG     = 9;
  localparam int OVERFLOW_FLAG        = 10;
  localparam int UNDERFLOW_FLAG       = 11;
  localparam int INEXACT_FLAG         = 12;
  localparam int INV_COUNT            = 9;

  // status-control register bit positions
  localparam int INVALID_OP_ENABLE         = 24;
  localparam int OVERFLOW_ENABLE           = 25;
  localparam int UNDERFLOW_ENABLE          = 26;
  localparam int ZERO_DIVIDE_ENABLE        = 27;
  localparam int INEXACT_ENABLE            = 28;
  localparam int INVALID_OP_SUMMARY        = 29;
  localparam int ENABLED_EXCEPTION_SUMMARY = 30;
  localparam int FP_EXCEPTION_SUMMARY      = 31;

  // byte addresses on the register bus
  localparam logic [3:0] ADDR_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_SET_STATUS_BIT = 4'h4;
  localparam logic [3:0] ADDR_MACHINE_STATE  = 4'h8;
  localparam logic [3:0] ADDR_EXCEPTION_INFO = 4'hC;

  // reset values
  localparam logic [FLAG_W-1:0]   FLAGS_RESET   = 13'h0000;
  localparam logic [ENABLE_W-1:0] ENABLES_RESET = 5'h00;
  localparam logic [1:0]          MODE_RESET    = 2'h0;
  localparam logic [TAG_W-1:0]    TAG_RESET     = 8'h00;

  // imprecise delivery lag
  localparam int CLOCK_PERIOD_NS     = 100;
  localparam int IMPRECISE_LAG_NS    = 800;
  localparam int IMPRECISE_LAG_CYCLES =
    (IMPRECISE_LAG_NS / CLOCK_PERIOD_NS) < 1 ? 1 : (IMPRECISE_LAG_NS / CLOCK_PERIOD_NS);
  localparam logic [3:0] LAG_LAST   = 4'(IMPRECISE_LAG_CYCLES - 1);

  // trap mode = {fp_trap_mode_bit_a, fp_trap_mode_bit_b}
  typedef enum logic [1:0] {
    MODE_IGNORE     = 2'b00,
    MODE_IMP_NONREC = 2'b01,
    MODE_IMP_REC    = 2'b10,
    MODE_PRECISE    = 2'b11
  } trap_mode_t;

  typedef enum logic [0:0] {
    DLV_IDLE    = 1'b0,
    DLV_PENDING = 1'b1
  } dlv_state_t;

  // enables {inexact, zero divide, underflow, overflow, invalid} to per-flag mask
  function automatic logic [FLAG_W-1:0] enable_mask(input logic [ENABLE_W-1:0] en);
    logic [FLAG_W-1:0] m;
    m = {FLAG_W{1'b0}};
    m[INV_COUNT-1:0]    = {INV_COUNT{en[0]}};
    m[OVERFLOW_FLAG]    = en[1];
    m[UNDERFLOW_FLAG]   = en[2];
    m[ZERO_DIVIDE_FLAG] = en[3];
    m[INEXACT_FLAG]     = en[4];
    return m;
  endfunction

endpackage

// ===== logic/cond_check_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cond_check_if;
  logic [12:0] cond;
  logic [4:0]  enables;
  logic        hit;
  logic        suppress;
  logic        legal;

  modport checker_side (input cond, input enables, output hit, output suppress, output legal);
  modport core_side    (output cond, output enables, input hit, input suppress, input legal);
endinterface
`default_nettype wire

// ===== logic/cond_classifier.sv
`timescale 1ns/1ps
`default_nettype none
module cond_classifier (
  cond_check_if.checker_side ck
);
  logic [fp_exc_pkg::FLAG_W-1:0] gated;
  logic [8:0]                    inv;
  logic [3:0]                    other;

  always_comb begin
    gated = ck.cond & fp_exc_pkg::enable_mask(ck.enables); // [RL2]
    inv   = ck.cond[8:0];
    other = ck.cond[12:9];
  end

  // any raised condition under a set enable
  assign ck.hit = |gated; // [RL4]

  // enabled invalid or enabled zero divide suppresses the write
  assign ck.suppress = (|gated[8:0]) | gated[fp_exc_pkg::ZERO_DIVIDE_FLAG]; // [RL11]

  // only the documented multi-flag combinations
  always_comb begin
    if (inv == 9'h000) begin
      ck.legal = $onehot0(other) || other == 4'hA || other == 4'hC; // [RL9]
    end else if (other == 4'h0) begin
      ck.legal = $onehot0(inv) || inv == 9'h011 || inv == 9'h021 || inv == 9'h081; // [RL10]
    end else begin
      ck.legal = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== logic/fp_exception_unit.sv
// Notes on behaviour
// RL1: one sticky flag per condition and category
// RL2: raising decided only by instruction and operands
// RL3: no enabled condition: default result written
// RL4: enabled condition sets flags and summary
// RL5: completed instruction with summary traps if mode
// RL6: summary set on any flag rising
// RL7: software setting a flag sets summary
// RL8: enabled summary is flags and enables
// RL9: inexact pairs only with overflow or underflow
// RL10: signaling NaN pairs in three cases only
// RL11: enabled invalid or zero divide suppresses write
// RL12: all other conditions write a result
// RL13: enable selects trap value or default value
// RL14: trap mode never changes stored results
// RL15: ignore mode never raises program exception
// RL16: nonrecoverable mode raises late, tag invalid
// RL17: recoverable mode raises late, tag, pipeline held
// RL18: precise mode raises at faulting instruction
// RL19: disabled conditions never raise the exception
// RL20: status access forces pending delivery
// RL21: software uses imprecise mode for traps
// RL22: software avoids ignore mode with enables
// RL23: enables at status bits 24 to 28
// RL24: flags stay set until software clears
//
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module fp_exception_unit (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [3:0]  avAddress,
  input  wire logic        avRead,
  input  wire logic        avWrite,
  input  wire logic [31:0] avWriteData,
  output logic      [31:0] avReadData,
  output logic             avWaitRequest,
  input  wire logic        opValid,
  input  wire logic [12:0] opCond,
  input  wire logic [7:0]  opTag,
  output logic             resValid,
  output logic             resWrite,
  output logic             resTrapValue,
  output logic      [7:0]  resTag,
  output logic             pairError,
  output logic             progExc,
  output logic      [7:0]  excTag,
  output logic             excTagValid,
  output logic             pipeHold
);

  localparam int DlvMax = fp_exc_pkg::IMPRECISE_LAG_CYCLES + 1;

  cond_check_if ck ();

  cond_classifier u_classifier (
    .ck (ck.checker_side)
  );

  logic [12:0]              flags_q;
  logic [12:0]              flags_d;
  logic [4:0]               enables_q;
  logic [4:0]               enables_d;
  logic                     fx_q;
  logic                     fx_d;
  fp_exc_pkg::trap_mode_t   trapMode_q;
  fp_exc_pkg::dlv_state_t   dlvState_q;
  logic [3:0]               lagCnt_q;
  logic                     waitReq_q;
  logic [31:0]              readData_q;
  logic                     resValid_q;
  logic                     resWrite_q;
  logic                     resTrapValue_q;
  logic [7:0]               resTag_q;
  logic                     pairError_q;
  logic                     progExc_q;
  logic [7:0]               excTag_q;
  logic                     excTagValid_q;
  logic                     pipeHold_q;
  logic                     fexPrev_q;
  logic                     swWrPrev_q;
  logic                     busReq;
  logic                     capture;
  logic                     accept;
  logic                     wrStatus;
  logic                     wrSetBit;
  logic                     wrMachine;
  logic                     statusAccess;
  logic [4:0]               setIdx;
  logic                     fexNow;
  logic                     opRise;
  logic                     opTrigger;
  logic                     swTrigger;
  logic                     trigger;
  logic                     lagDone;
  logic                     raiseNow;

  assign ck.cond    = opCond;
  assign ck.enables = enables_q;

  // bus decode: request seen with waitrequest high, done one edge later
  assign busReq       = avRead | avWrite;
  assign capture      = busReq & waitReq_q;
  assign accept       = busReq & ~waitReq_q;
  assign wrStatus     = accept & avWrite & (avAddress == fp_exc_pkg::ADDR_STATUS_CONTROL);
  assign wrSetBit     = accept & avWrite & (avAddress == fp_exc_pkg::ADDR_SET_STATUS_BIT);
  assign wrMachine    = accept & avWrite & (avAddress == fp_exc_pkg::ADDR_MACHINE_STATE);
  assign statusAccess = accept & ((avAddress == fp_exc_pkg::ADDR_STATUS_CONTROL) |
                                  (avAddress == fp_exc_pkg::ADDR_SET_STATUS_BIT));
  assign setIdx       = avWriteData[4:0];

  // enabled summary from flags and enables
  assign fexNow = |(flags_q & fp_exc_pkg::enable_mask(enables_q)); // [RL8]
  assign opRise = opValid & (|(opCond & ~flags_q));

  assign opTrigger = opValid & ck.hit; // [RL5] [RL19]
  assign swTrigger = swWrPrev_q & fexNow & ~fexPrev_q;
  assign trigger   = opTrigger | swTrigger;
  assign lagDone   = (lagCnt_q == fp_exc_pkg::LAG_LAST);
  assign raiseNow  = (dlvState_q == fp_exc_pkg::DLV_PENDING) & (trapMode_q != fp_exc_pkg::MODE_IGNORE) &
                     (lagDone | statusAccess);

  // waitrequest handshake
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      waitReq_q <= 1'b1;
    end else begin
      waitReq_q <= ~capture;
    end
  end

  // read data captured at the edge that drops waitrequest
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      readData_q <= 32'h00000000;
    end else if (capture && avRead) begin
      case (avAddress)
        fp_exc_pkg::ADDR_STATUS_CONTROL: begin
          readData_q <= {fx_q, fexNow, |flags_q[8:0], enables_q, 11'h000, flags_q}; // [RL23]
        end
        fp_exc_pkg::ADDR_MACHINE_STATE: begin
          readData_q <= {30'h00000000, trapMode_q};
        end
        fp_exc_pkg::ADDR_EXCEPTION_INFO: begin
          readData_q <= {22'h000000, pipeHold_q, dlvState_q, excTag_q};
        end
        default: begin
          readData_q <= 32'h00000000;
        end
      endcase
    end
  end

  // condition flags: hardware set wins over software clear
  always_comb begin
    flags_d = wrStatus ? avWriteData[12:0] : flags_q; // [RL24]
    if (wrSetBit && setIdx < 5'(fp_exc_pkg::FLAG_W)) begin
      flags_d[setIdx[3:0]] = 1'b1;
    end
    if (opValid) begin
      flags_d = flags_d | opCond; // [RL1]
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      flags_q <= fp_exc_pkg::FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // enables at status bits 24 to 28
  always_comb begin
    enables_d = wrStatus ? avWriteData[fp_exc_pkg::INEXACT_ENABLE:fp_exc_pkg::INVALID_OP_ENABLE] : enables_q; // [RL23]
    if (wrSetBit && setIdx >= 5'(fp_exc_pkg::INVALID_OP_ENABLE) && setIdx <= 5'(fp_exc_pkg::INEXACT_ENABLE)) begin
      enables_d[3'(setIdx - 5'(fp_exc_pkg::INVALID_OP_ENABLE))] = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      enables_q <= fp_exc_pkg::ENABLES_RESET;
    end else begin
      enables_q <= enables_d;
    end
  end

  // exception summary
  always_comb begin
    fx_d = fx_q;
    if (wrStatus) begin
      fx_d = avWriteData[fp_exc_pkg::FP_EXCEPTION_SUMMARY] | (|avWriteData[12:0]); // [RL7]
    end
    if (wrSetBit && (setIdx < 5'(fp_exc_pkg::FLAG_W) || setIdx == 5'(fp_exc_pkg::FP_EXCEPTION_SUMMARY))) begin
      fx_d = 1'b1; // [RL7]
    end
    if (opRise || opTrigger) begin
      fx_d = 1'b1; // [RL6] [RL4]
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fx_q <= 1'b0;
    end else begin
      fx_q <= fx_d;
    end
  end

  // trap mode bits
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      trapMode_q <= fp_exc_pkg::trap_mode_t'(fp_exc_pkg::MODE_RESET);
    end else if (wrMachine) begin
      trapMode_q <= fp_exc_pkg::trap_mode_t'(avWriteData[1:0]);
    end
  end

  // edge detect of software-caused enabled summary
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fexPrev_q  <= 1'b0;
      swWrPrev_q <= 1'b0;
    end else begin
      fexPrev_q  <= fexNow;
      swWrPrev_q <= wrStatus | wrSetBit;
    end
  end

  // result completion, independent of trap mode
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      resValid_q     <= 1'b0;
      resWrite_q     <= 1'b0;
      resTrapValue_q <= 1'b0;
      resTag_q       <= fp_exc_pkg::TAG_RESET;
    end else begin
      resValid_q     <= opValid;
      resWrite_q     <= opValid & ~ck.suppress; // [RL3] [RL11] [RL12] [RL14]
      resTrapValue_q <= opValid & ck.hit; // [RL13]
      if (opValid) begin
        resTag_q <= opTag;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pairError_q <= 1'b0;
    end else begin
      pairError_q <= opValid & ~ck.legal; // [RL9] [RL10]
    end
  end

  // delivery state
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dlvState_q <= fp_exc_pkg::DLV_IDLE;
      lagCnt_q   <= 4'h0;
    end else begin
      case (dlvState_q)
        fp_exc_pkg::DLV_IDLE: begin
          lagCnt_q <= 4'h0;
          if (trigger && (trapMode_q == fp_exc_pkg::MODE_IMP_NONREC ||
                          trapMode_q == fp_exc_pkg::MODE_IMP_REC)) begin
            dlvState_q <= fp_exc_pkg::DLV_PENDING; // [RL16] [RL17]
          end
        end
        fp_exc_pkg::DLV_PENDING: begin
          lagCnt_q <= lagCnt_q + 4'h1;
          if (trapMode_q == fp_exc_pkg::MODE_IGNORE || raiseNow) begin
            dlvState_q <= fp_exc_pkg::DLV_IDLE; // [RL20]
          end
        end
        default: begin
          dlvState_q <= fp_exc_pkg::DLV_IDLE;
        end
      endcase
    end
  end

  // program exception pulse
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      progExc_q <= 1'b0;
    end else begin
      progExc_q <= ((dlvState_q == fp_exc_pkg::DLV_IDLE) & trigger &
                    (trapMode_q == fp_exc_pkg::MODE_PRECISE)) | raiseNow; // [RL15] [RL18] [RL20]
    end
  end

  // faulting instruction identity
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      excTag_q      <= fp_exc_pkg::TAG_RESET;
      excTagValid_q <= 1'b0;
    end else if (dlvState_q == fp_exc_pkg::DLV_IDLE && trigger &&
                 trapMode_q != fp_exc_pkg::MODE_IGNORE) begin
      excTag_q      <= opTrigger ? opTag : fp_exc_pkg::TAG_RESET;
      excTagValid_q <= opTrigger & (trapMode_q != fp_exc_pkg::MODE_IMP_NONREC); // [RL16] [RL17]
    end
  end

  // recoverable mode holds younger instructions until delivery
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pipeHold_q <= 1'b0;
    end else if (dlvState_q == fp_exc_pkg::DLV_IDLE) begin
      pipeHold_q <= trigger & (trapMode_q == fp_exc_pkg::MODE_IMP_REC); // [RL17]
    end else if (trapMode_q == fp_exc_pkg::MODE_IGNORE || raiseNow) begin
      pipeHold_q <= 1'b0;
    end
  end

  assign avReadData    = readData_q;
  assign avWaitRequest = waitReq_q;
  assign resValid      = resValid_q;
  assign resWrite      = resWrite_q;
  assign resTrapValue  = resTrapValue_q;
  assign resTag        = resTag_q;
  assign pairError     = pairError_q;
  assign progExc       = progExc_q;
  assign excTag        = excTag_q;
  assign excTagValid   = excTagValid_q;
  assign pipeHold      = pipeHold_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_impStart;
    dlvState_q == fp_exc_pkg::DLV_IDLE && trigger &&
      (trapMode_q == fp_exc_pkg::MODE_IMP_NONREC || trapMode_q == fp_exc_pkg::MODE_IMP_REC);
  endsequence

  sequence s_forced;
    dlvState_q == fp_exc_pkg::DLV_PENDING && trapMode_q != fp_exc_pkg::MODE_IGNORE && statusAccess;
  endsequence

  a_flag_record: assert property (opValid |=> ((flags_q & $past(opCond)) == $past(opCond))) // [RL1]
    else $error("raised condition flag not recorded");
  a_flag_sticky: assert property (!wrStatus |=> ((flags_q & $past(flags_q)) == $past(flags_q))) // [RL24]
    else $error("flag cleared without status write");
  a_summary_rise: assert property (opRise |=> fx_q) // [RL6]
    else $error("summary not set on flag rise");
  a_suppress_write: assert property (opValid && ck.suppress |=> resValid_q && !resWrite_q) // [RL11]
    else $error("enabled invalid or zero divide wrote result");
  a_deliver_write: assert property (opValid && !ck.suppress |=> resWrite_q && resTag_q == $past(opTag)) // [RL12]
    else $error("result not written");
  a_default_value: assert property (opValid && !ck.hit |=> resWrite_q && !resTrapValue_q) // [RL3]
    else $error("default result not delivered");
  a_ignore_mode: assert property ($past(trapMode_q) == fp_exc_pkg::MODE_IGNORE |-> !progExc_q) // [RL15]
    else $error("exception raised in ignore mode");
  a_precise_raise: assert property (opValid && ck.hit && dlvState_q == fp_exc_pkg::DLV_IDLE &&
    trapMode_q == fp_exc_pkg::MODE_PRECISE |=> progExc_q && excTag_q == $past(opTag)) // [RL18]
    else $error("precise exception not at faulting instruction");
  a_imprecise_bound: assert property (disable iff (!rst_b || trapMode_q == fp_exc_pkg::MODE_IGNORE) // [RL16]
    s_impStart |-> ##[1:DlvMax] progExc_q)
    else $error("imprecise exception not delivered in time");
  a_force_deliver: assert property (s_forced |=> progExc_q && !pipeHold_q) // [RL20]
    else $error("status access did not force delivery");
  a_hold_recov: assert property (s_impStart and trapMode_q == fp_exc_pkg::MODE_IMP_REC |=> pipeHold_q) // [RL17]
    else $error("pipeline not held in recoverable mode");
  a_disabled_quiet: assert property (dlvState_q == fp_exc_pkg::DLV_IDLE && !trigger |=> !progExc_q) // [RL19]
    else $error("exception without enabled condition");
  a_pair_flag: assert property (opValid && !ck.legal |=> pairError_q) // [RL9]
    else $error("illegal condition pairing not flagged");

endmodule
`default_nettype wire

// ===== test/exc_sequencer_model.sv
`timescale 1ns/1ps
`default_nettype none
module exc_sequencer_model (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       progExc,
  input  wire logic [7:0] excTag,
  input  wire logic       excTagValid,
  output logic      [7:0] excCount,
  output logic      [7:0] lastTag,
  output logic            lastTagValid
);
  // enters the handler once per request pulse, keeps the identity seen
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      excCount     <= 8'h00;
      lastTag      <= 8'h00;
      lastTagValid <= 1'b0;
    end else if (progExc) begin
      excCount     <= excCount + 8'h01;
      lastTag      <= excTag;
      lastTagValid <= excTagValid;
    end
  end
endmodule
`default_nettype wire

// ===== test/fp_exception_status_and_trap_mode_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fp_exception_status_and_trap_mode_tb;
  typedef struct packed {
    logic [4:0]  en;
    logic [12:0] cond;
    logic        wr;
    logic        trap;
    logic        pair;
  } row_t;
  localparam logic [3:0] aStat = fp_exc_pkg::ADDR_STATUS_CONTROL;
  localparam logic [3:0] aSet  = fp_exc_pkg::ADDR_SET_STATUS_BIT;
  localparam logic [3:0] aMode = fp_exc_pkg::ADDR_MACHINE_STATE;
  logic        clock;
  logic        rst_b;
  logic [3:0]  avAddress;
  logic        avRead;
  logic        avWrite;
  logic [31:0] avWriteData;
  logic [31:0] avReadData;
  logic        avWaitRequest;
  logic        opValid;
  logic [12:0] opCond;
  logic [7:0]  opTag;
  logic        resValid;
  logic        resWrite;
  logic        resTrapValue;
  logic [7:0]  resTag;
  logic        pairError;
  logic        progExc;
  logic [7:0]  excTag;
  logic        excTagValid;
  logic        pipeHold;
  logic [7:0]  excCount;
  logic [7:0]  lastTag;
  logic        lastTagValid;
  logic [31:0] rd;
  logic [7:0]  cnt0;
  int          errTotal;
  int          checked;
  int          cycles;
  int          n;
  row_t        rows [13] = '{
    '{5'h00, 13'h1400, 1'b1, 1'b0, 1'b0}, '{5'h02, 13'h0400, 1'b1, 1'b1, 1'b0},
    '{5'h01, 13'h0011, 1'b0, 1'b1, 1'b0}, '{5'h08, 13'h0200, 1'b0, 1'b1, 1'b0},
    '{5'h00, 13'h0200, 1'b1, 1'b0, 1'b0}, '{5'h10, 13'h1800, 1'b1, 1'b1, 1'b0},
    '{5'h00, 13'h0C00, 1'b1, 1'b0, 1'b1}, '{5'h01, 13'h0021, 1'b0, 1'b1, 1'b0},
    '{5'h01, 13'h0003, 1'b0, 1'b1, 1'b1}, '{5'h1F, 13'h1000, 1'b1, 1'b1, 1'b0},
    '{5'h00, 13'h0081, 1'b1, 1'b0, 1'b0}, '{5'h04, 13'h0100, 1'b1, 1'b0, 1'b0},
    '{5'h1E, 13'h0040, 1'b1, 1'b0, 1'b0}};

  fp_exception_unit u_dut (
    .clock, .rst_b, .avAddress, .avRead, .avWrite, .avWriteData, .avReadData, .avWaitRequest,
    .opValid, .opCond, .opTag, .resValid, .resWrite, .resTrapValue, .resTag, .pairError,
    .progExc, .excTag, .excTagValid, .pipeHold);

  exc_sequencer_model u_seq (
    .clock, .rst_b, .progExc, .excTag, .excTagValid, .excCount, .lastTag, .lastTagValid);

  initial clock = 1'b0;
  always #50 clock = ~clock;

  task automatic end_of_test();
    $display("mismatches %0d of %0d compares", errTotal, checked);
    if (errTotal == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      errTotal++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errTotal++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one transfer, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock);
    avAddress <= a;
    avWriteData <= d;
    avWrite <= w;
    avRead <= !w;
    @(posedge clock);
    while (avWaitRequest !== 1'b0) begin
      k++;
      @(posedge clock);
    end
    rd = avReadData;
    avWrite <= 1'b0;
    avRead <= 1'b0;
    chk("waitrequest", k, 32'h1);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk("readdata", rd, exp);
  endtask

  task automatic op(input logic [12:0] c, input logic [7:0] t);
    @(posedge clock);
    opValid <= 1'b1;
    opCond <= c;
    opTag <= t;
    @(posedge clock);
    opValid <= 1'b0;
    @(negedge clock);
  endtask

  function automatic logic [31:0] stw(input logic [4:0] e, input logic [12:0] c);
    logic [12:0] m;
    m = {e[4], e[2], e[1], e[3], {9{e[0]}}};
    return {|c, |(c & m), |c[8:0], e, 11'h000, c};
  endfunction

  initial begin
    errTotal = 0;
    checked = 0;
    cycles = 0;
    rst_b = 1'b0;
    avAddress = 4'h0;
    avRead = 1'b0;
    avWrite = 1'b0;
    avWriteData = 32'h0;
    opValid = 1'b0;
    opCond = 13'h0000;
    opTag = 8'h00;
    repeat (2) @(posedge clock);
    chk("waitrequest", avWaitRequest, 1'b1);
    chk("progExc", progExc, 1'b0);
    rst_b <= 1'b1;
    // ordinary cases in ignore mode
    for (int i = 0; i < 13; i++) begin
      bus(1'b1, aStat, {3'h0, rows[i].en, 24'h0});
      op(rows[i].cond, 8'(i));
      chk("resValid", resValid, 1'b1);
      chk("resTag", resTag, 8'(i));
      chk("resWrite", resWrite, rows[i].wr);
      chk("resTrapValue", resTrapValue, rows[i].trap);
      chk("pairError", pairError, rows[i].pair);
      rdc(aStat, stw(rows[i].en, rows[i].cond));
    end
    chk("excCount", excCount, 8'h00);
    // precise mode
    bus(1'b1, aStat, 32'h02000000);
    bus(1'b1, aMode, 32'h3);
    op(13'h0400, 8'h5A);
    chk("progExc", progExc, 1'b1);
    chk("excTag", excTag, 8'h5A);
    chk("excTagValid", excTagValid, 1'b1);
    chk("resWrite", resWrite, 1'b1);
    chk("resTrapValue", resTrapValue, 1'b1);
    @(negedge clock);
    chk("progExc", progExc, 1'b0);
    // disabled condition never traps
    bus(1'b1, aStat, 32'h1D000000);
    cnt0 = excCount;
    op(13'h0400, 8'h11);
    repeat (12) @(negedge clock);
    chk("excCount", excCount, cnt0);
    // imprecise recoverable
    bus(1'b1, aStat, 32'h01000000);
    bus(1'b1, aMode, 32'h2);
    op(13'h0001, 8'h33);
    chk("resWrite", resWrite, 1'b0);
    chk("pipeHold", pipeHold, 1'b1);
    n = 0;
    while (progExc !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    chk("lag", n, fp_exc_pkg::IMPRECISE_LAG_CYCLES);
    chk("excTag", excTag, 8'h33);
    chk("excTagValid", excTagValid, 1'b1);
    repeat (2) @(negedge clock);
    chk("pipeHold", pipeHold, 1'b0);
    chk("lastTag", lastTag, 8'h33);
    // imprecise nonrecoverable, forced by a status access
    bus(1'b1, aStat, 32'h01000000);
    bus(1'b1, aMode, 32'h1);
    cnt0 = excCount;
    op(13'h0001, 8'h44);
    bus(1'b0, aStat, 32'h0);
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk("excCount", excCount, cnt0 + 8'h01);
    chk("lastTagValid", lastTagValid, 1'b0);
    // switching to ignore drops a pending request
    bus(1'b1, aStat, 32'h01000000);
    bus(1'b1, aMode, 32'h2);
    cnt0 = excCount;
    op(13'h0001, 8'h55);
    bus(1'b1, aMode, 32'h0);
    repeat (12) @(negedge clock);
    chk("excCount", excCount, cnt0);
    rdc(fp_exc_pkg::ADDR_EXCEPTION_INFO, 32'h00000055);
    // set-bit access, stickiness and clearing
    bus(1'b1, aStat, 32'h0);
    bus(1'b1, aSet, 32'hC);
    rdc(aStat, 32'h80001000);
    op(13'h0000, 8'h66);
    rdc(aStat, 32'h80001000);
    bus(1'b1, aStat, 32'h0);
    rdc(aStat, 32'h0);
    bus(1'b1, aSet, 32'h19);
    rdc(aStat, 32'h02000000);
    rdc(4'h2, 32'h0);
    bus(1'b1, aMode, 32'h3);
    rdc(aMode, 32'h3);
    // reset in mid-run
    @(posedge clock);
    rst_b <= 1'b0;
    @(negedge clock);
    chk("waitrequest", avWaitRequest, 1'b1);
    chk("pipeHold", pipeHold, 1'b0);
    @(posedge clock);
    rst_b <= 1'b1;
    rdc(aStat, 32'h0);
    rdc(aMode, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
